// >>> src/arec_excite.sv
`timescale 1ns/1ns
`default_nettype none
module arec_excite (
  input wire logic [7:0] ctrl_i,
  input wire logic [1:0] pair_i,
  output arec_pkg::arec_exc_t exc_o
);

  logic s1_en, s2_en, s1_sel, s2_sel;

  // ****************************************
  // Source routing decode
  // ****************************************
  always_comb begin
    s1_en = ctrl_i[arec_pkg::EXC_SRC1_EN_BIT];
    s2_en = ctrl_i[arec_pkg::EXC_SRC2_EN_BIT];
    s1_sel = ctrl_i[arec_pkg::EXC_SRC1_SEL_BIT];
    s2_sel = ctrl_i[arec_pkg::EXC_SRC2_SEL_BIT];
    exc_o.src1_analog_input_seven = s1_en && !s1_sel; // RQ10 RQ11
    exc_o.src1_analog_input_eight = s1_en && s1_sel; // RQ10 RQ11
    exc_o.src2_analog_input_eight = s2_en && !s2_sel; // RQ9 RQ11
    exc_o.src2_analog_input_seven = s2_en && s2_sel; // RQ9 RQ11
    // Both sources may land on one pin; count shows the doubled drive
    exc_o.analog_input_seven_count = {1'b0, exc_o.src1_analog_input_seven} + {1'b0, exc_o.src2_analog_input_seven}; // RQ15
    exc_o.analog_input_eight_count = {1'b0, exc_o.src1_analog_input_eight} + {1'b0, exc_o.src2_analog_input_eight}; // RQ15
    exc_o.burnout_56 = ctrl_i[arec_pkg::EXC_BURNOUT_BIT]
                       && (pair_i == arec_pkg::PAIR_56); // RQ8
    exc_o.burnout_78 = ctrl_i[arec_pkg::EXC_BURNOUT_BIT]
                       && (pair_i == arec_pkg::PAIR_78); // RQ8
  end

endmodule
`default_nettype wire

// >>> src/arec_pkg.sv
package arec_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] DECIM_ADDR = 8'hD4;
  localparam logic [7:0] EXC_ADDR = 8'hD5;
  localparam logic [7:0] DECIM_RESET = 8'h45;
  localparam logic [7:0] EXC_RESET = 8'h00;

  // ****************************************
  // Excitation control fields
  // ****************************************
  localparam int EXC_BURNOUT_BIT = 6;
  localparam int EXC_SRC2_SEL_BIT = 3;
  localparam int EXC_SRC1_SEL_BIT = 2;
  localparam int EXC_SRC2_EN_BIT = 1;
  localparam int EXC_SRC1_EN_BIT = 0;
  localparam logic [7:0] EXC_IMPL_MASK = 8'h4F;

  // ****************************************
  // Rate and timing
  // ****************************************
  localparam int TIMEBASE_HZ = 32768;
  localparam int RATE_BASE = 8;
  localparam int CHOP_FACTOR = 3;
  localparam logic [7:0] CHOP_MIN_WORD = 8'h0D;
  localparam logic [7:0] NOCHOP_MIN_WORD = 8'h01;
  localparam int PERIOD_W = 13;

  // Primary channel pair codes
  localparam logic [1:0] PAIR_OTHER = 2'h0;
  localparam logic [1:0] PAIR_56 = 2'h1;
  localparam logic [1:0] PAIR_78 = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } arec_sfr_req_t;

  typedef struct packed {
    logic src1_analog_input_seven;
    logic src1_analog_input_eight;
    logic src2_analog_input_seven;
    logic src2_analog_input_eight;
    logic [1:0] analog_input_seven_count;
    logic [1:0] analog_input_eight_count;
    logic burnout_56;
    logic burnout_78;
  } arec_exc_t;

endpackage

// >>> src/arec_rate_gen.sv
`timescale 1ns/1ns
`default_nettype none
module arec_rate_gen #(
  parameter int PERIOD_W = arec_pkg::PERIOD_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic [PERIOD_W-1:0] period_i,
  output logic done_o,
  output logic [PERIOD_W-1:0] count_o
);

  logic [PERIOD_W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;

  // ****************************************
  // Decimation counter
  // ****************************************
  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (tick_i) begin
      // Compare with >= so a shortened period never overruns
      if (cnt_q >= period_i - PERIOD_W'(1)) begin
        cnt_d = '0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + PERIOD_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
  assign count_o = cnt_q;

endmodule
`default_nettype wire

// >>> src/arec_top.sv
// How it works
// RQ1: The decimation word register sets the filter decimation factor and so the result rate.
// RQ2: With chopping on a result comes every three times eight times the word timebase ticks.
// RQ3: With chopping off a result comes every eight times the word timebase ticks.
// RQ4: Chopping is on when the chop-disable bit is 0 and off when it is 1.
// RQ5: With chopping on a word below 13 is used as 13.
// RQ6: During calibration the programmed word stays in use and is never forced to 255.
// RQ7: Software should load 255 before a calibration for best results.
// RQ8: The burnout enable bit drives burnout currents only on input pairs five/six or seven/eight.
// RQ9: Source two goes to input eight when its select bit is 0 and input seven when it is 1.
// RQ10: Source one goes to input seven when its select bit is 0 and input eight when it is 1.
// RQ11: Each source is on only while its enable bit is set.
// RQ12: An excitation write acts at once and never restarts the conversion sequence.
// RQ13: After a source change software discards results until the third or fourth one.
// RQ14: Bits 7, 5 and 4 of the excitation register ignore writes.
// RQ15: Both sources may select the same pin, doubling its drive.
// RQ16: A counter on the timebase ticks ends each conversion with a one-cycle done strobe.
// RQ17: The unimplemented excitation bits read as zero.
`timescale 1ns/1ns
`default_nettype none
module arec_top #(
  parameter int PERIOD_W = arec_pkg::PERIOD_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire arec_pkg::arec_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic chop_disable_bit_i,
  input wire logic cal_active_i,
  input wire logic mod_tick_i,
  input wire logic [1:0] prim_pair_i,
  output logic conv_done_o,
  output logic [7:0] decimation_value_o,
  output arec_pkg::arec_exc_t exc_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] eff_word(input logic [7:0] w, input logic chop_on);
    logic [7:0] lim;
    lim = chop_on ? arec_pkg::CHOP_MIN_WORD : arec_pkg::NOCHOP_MIN_WORD;
    eff_word = (w < lim) ? lim : w; // RQ5
  endfunction

  function automatic logic [PERIOD_W-1:0] conv_period(input logic [7:0] w,
                                                      input logic chop_on);
    logic [PERIOD_W-1:0] base;
    base = PERIOD_W'(arec_pkg::RATE_BASE) * PERIOD_W'(w);
    conv_period = chop_on ? PERIOD_W'(arec_pkg::CHOP_FACTOR) * base : base; // RQ2 RQ3
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] decim_q, decim_d;
  logic [7:0] exc_ctrl_q, exc_ctrl_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] eff_q, eff_d;
  arec_pkg::arec_exc_t exc_q, exc_d;
  logic chop_on;
  logic wr_decim, wr_exc;
  logic [PERIOD_W-1:0] period;
  logic [PERIOD_W-1:0] rate_count;
  logic done;

  assign chop_on = !chop_disable_bit_i; // RQ4
  assign wr_decim = sfr_req_i.wr && (sfr_req_i.addr == arec_pkg::DECIM_ADDR);
  assign wr_exc = sfr_req_i.wr && (sfr_req_i.addr == arec_pkg::EXC_ADDR);

  always_comb begin
    decim_d = decim_q;
    exc_ctrl_d = exc_ctrl_q;
    rdata_d = rdata_q;
    // Calibration does not touch the word
    if (wr_decim) begin
      decim_d = sfr_req_i.wdata; // RQ1 RQ6
    end
    if (wr_exc) begin
      exc_ctrl_d = sfr_req_i.wdata & arec_pkg::EXC_IMPL_MASK; // RQ14
    end
    if (sfr_req_i.rd) begin
      case (sfr_req_i.addr)
        arec_pkg::DECIM_ADDR: rdata_d = decim_q;
        arec_pkg::EXC_ADDR: rdata_d = exc_ctrl_q; // RQ17
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      decim_q <= arec_pkg::DECIM_RESET;
      exc_ctrl_q <= arec_pkg::EXC_RESET;
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      decim_q <= decim_d;
      exc_ctrl_q <= exc_ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Conversion rate
  // ****************************************
  // Period follows the live chop setting; takes hold at the next tick, inside the running conversion
  assign period = conv_period(eff_word(decim_q, chop_on), chop_on); // RQ1

  arec_rate_gen #(
    .PERIOD_W(PERIOD_W)
  ) u_rate (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .tick_i(mod_tick_i),
    .period_i(period),
    .done_o(done),
    .count_o(rate_count)
  ); // RQ16

  // ****************************************
  // Excitation outputs
  // ****************************************
  // No link to the rate counter, so writes never restart a conversion
  arec_excite u_exc (
    .ctrl_i(exc_ctrl_q),
    .pair_i(prim_pair_i),
    .exc_o(exc_d)
  ); // RQ12

  assign eff_d = eff_word(decim_q, chop_on);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      exc_q <= '0;
      eff_q <= arec_pkg::DECIM_RESET;
    end else if (ce_i) begin
      exc_q <= exc_d;
      eff_q <= eff_d;
    end
  end

  assign exc_o = exc_q;
  assign decimation_value_o = eff_q;
  assign conv_done_o = done;
  assign sfr_rdata_o = rdata_q;

  // ****************************************
  // Assertions
  // ****************************************
  // Tick count per conversion, checked only when the period held all along
  logic [PERIOD_W-1:0] since_done_q;
  logic [PERIOD_W-1:0] period_q;
  logic period_stable_q;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      since_done_q <= '0;
      period_q <= '0;
      period_stable_q <= 1'b0;
    end else if (ce_i) begin
      period_q <= period;
      if (done) begin
        // A tick in the strobe cycle already belongs to the next conversion
        since_done_q <= PERIOD_W'(mod_tick_i);
        period_stable_q <= 1'b1;
      end else if (mod_tick_i) begin
        since_done_q <= since_done_q + PERIOD_W'(1);
      end
      if (period != period_q) begin
        period_stable_q <= 1'b0;
      end
    end
  end

  a_clamp_min_word: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ5
    (ce_i && chop_on && decim_q < 8'h0D) |=> (decimation_value_o == 8'h0D))
    else $error("Chop-on word below 13 not clamped");

  a_period_chop_on: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ2
    chop_on |-> (period == PERIOD_W'(24)
      * ((decim_q < 8'h0D) ? PERIOD_W'(13) : PERIOD_W'(decim_q))))
    else $error("Chop-on period not 24 times word");

  a_period_chop_off: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ3
    (!chop_on && decim_q != 8'h00) |-> (period == PERIOD_W'(8) * PERIOD_W'(decim_q)))
    else $error("Chop-off period not 8 times word");

  a_chop_sense: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ4
    (chop_disable_bit_i && decim_q == 8'h03) |-> (period == PERIOD_W'(24)))
    else $error("Chop-disable bit sensed wrongly");

  a_cal_keeps_word: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ6
    (ce_i && cal_active_i && !wr_decim) |=> (decim_q == $past(decim_q)))
    else $error("Word changed during calibration");

  a_done_spacing: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ16
    (done && period_stable_q) |-> (since_done_q == period))
    else $error("Done strobe at wrong tick count");

  a_done_single: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ16
    (ce_i && done) |=> !done)
    else $error("Done strobe longer than one cycle");

  a_write_no_restart: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ12
    (ce_i && wr_exc && !mod_tick_i) |=> (rate_count == $past(rate_count)))
    else $error("Excitation write disturbed conversion");

  a_src_routing: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ9
    (ce_i && wr_exc && sfr_req_i.wdata[3:0] == 4'hA) ##1 ce_i
    |=> (exc_o.src2_analog_input_seven && !exc_o.src2_analog_input_eight && !exc_o.src1_analog_input_seven && !exc_o.src1_analog_input_eight))
    else $error("Source two not routed to input seven");

  a_src1_to_eight: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ10
    (ce_i && wr_exc && sfr_req_i.wdata[3:0] == 4'h7) ##1 ce_i
    |=> (exc_o.src1_analog_input_eight && exc_o.src2_analog_input_eight && exc_o.analog_input_eight_count == 2'h2))
    else $error("Source one or shared pin drive wrong");

  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ17
    (ce_i && sfr_req_i.rd && sfr_req_i.addr == arec_pkg::EXC_ADDR)
    |=> (sfr_rdata_o[7] == 1'b0 && sfr_rdata_o[5:4] == 2'h0))
    else $error("Unimplemented bits read nonzero");

  a_burnout_pairs: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ8
    (ce_i && (prim_pair_i == arec_pkg::PAIR_OTHER || !exc_ctrl_q[6]))
    |=> (!exc_o.burnout_56 && !exc_o.burnout_78))
    else $error("Burnout enabled off allowed pairs");

  a_write_lands: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
    (ce_i && wr_decim) |=> (decim_q == $past(sfr_req_i.wdata)))
    else $error("Decimation word write lost");

  a_read_decim: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
    (ce_i && sfr_req_i.rd && sfr_req_i.addr == arec_pkg::DECIM_ADDR)
    |=> (sfr_rdata_o == $past(decim_q)))
    else $error("Decimation word read back wrong");

  a_unmapped_read: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ17
    (ce_i && sfr_req_i.rd && sfr_req_i.addr != arec_pkg::DECIM_ADDR
      && sfr_req_i.addr != arec_pkg::EXC_ADDR) |=> (sfr_rdata_o == 8'h00))
    else $error("Unmapped read not zero");

  a_word_unclamped: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ5
    (ce_i && chop_on && decim_q >= 8'h0D) |=> (decimation_value_o == $past(decim_q)))
    else $error("Chop-on word altered although not below 13");

  a_nochop_word: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ3
    (ce_i && !chop_on)
    |=> (decimation_value_o == (($past(decim_q) == 8'h00) ? 8'h01 : $past(decim_q))))
    else $error("Chop-off effective word wrong");

  a_src1_enable: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ11
    (ce_i && !exc_ctrl_q[arec_pkg::EXC_SRC1_EN_BIT])
    |=> !(exc_o.src1_analog_input_seven || exc_o.src1_analog_input_eight))
    else $error("Source one drives while disabled");

  a_src2_enable: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ11
    (ce_i && !exc_ctrl_q[arec_pkg::EXC_SRC2_EN_BIT])
    |=> !(exc_o.src2_analog_input_seven || exc_o.src2_analog_input_eight))
    else $error("Source two drives while disabled");

  a_src1_seven: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ10
    (ce_i && exc_ctrl_q[0] && !exc_ctrl_q[2]) |=> (exc_o.src1_analog_input_seven && !exc_o.src1_analog_input_eight))
    else $error("Source one not routed to input seven");

  a_src2_eight: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ9
    (ce_i && exc_ctrl_q[1] && !exc_ctrl_q[3]) |=> (exc_o.src2_analog_input_eight && !exc_o.src2_analog_input_seven))
    else $error("Source two not routed to input eight");

  a_unimpl_dropped: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ14
    (ce_i && wr_exc) |=> (exc_ctrl_q[7] == 1'b0 && exc_ctrl_q[5:4] == 2'h0
      && exc_ctrl_q[6] == $past(sfr_req_i.wdata[6])))
    else $error("Unimplemented excitation bits kept");

  a_pin7_double: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ15
    (exc_o.src1_analog_input_seven && exc_o.src2_analog_input_seven) |-> (exc_o.analog_input_seven_count == 2'h2))
    else $error("Input seven drive count wrong");

  a_pin8_double: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ15
    (exc_o.src1_analog_input_eight && exc_o.src2_analog_input_eight) |-> (exc_o.analog_input_eight_count == 2'h2))
    else $error("Input eight drive count wrong");

  // Clock enable low must hold the word and excitation registers, the counter and the done strobe
  a_ce_freeze: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ16
    !ce_i |=> (decim_q == $past(decim_q) && exc_ctrl_q == $past(exc_ctrl_q)
      && rate_count == $past(rate_count) && conv_done_o == $past(conv_done_o)))
    else $error("State moved while clock enable was low");

  a_rdata_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ17
    !(ce_i && sfr_req_i.rd) |=> $stable(sfr_rdata_o))
    else $error("Read data moved without a read");

  // ****************************************
  // Cover points
  // ****************************************

  c_conv_done: cover property (@(posedge clk_i) disable iff (!rstn_i) done);

  c_cal_done: cover property (@(posedge clk_i) disable iff (!rstn_i)
    cal_active_i && done);

  c_double_drive: cover property (@(posedge clk_i) disable iff (!rstn_i)
    exc_o.analog_input_seven_count == 2'h2);

  c_chop_off_done: cover property (@(posedge clk_i) disable iff (!rstn_i)
    !chop_on && done);

  c_burnout_pair: cover property (@(posedge clk_i) disable iff (!rstn_i)
    exc_o.burnout_56 || exc_o.burnout_78);

endmodule
`default_nettype wire

// >>> tb/arec_mod_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Modulator timebase model
// ****************************************
module arec_mod_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] gap_i,
  output logic tick_o
);
  logic [3:0] cnt_q;
  // One-cycle tick every gap_i+1 clocks; gap_i above 0 keeps ticks apart
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= 4'h0;
      tick_o <= 1'b0;
    end else if (cnt_q >= gap_i) begin
      cnt_q <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i, rstn_i, ce_i, chop_i, cal_i, tick, done;
  logic [3:0] gap;
  logic [1:0] pair;
  logic [7:0] rdata, dval, d;
  arec_pkg::arec_sfr_req_t req;
  arec_pkg::arec_exc_t exc;
  int err_count, check_count;
  // ****************************************
  // Tables: {pair, word} and {chop off, word, effective word}
  // ****************************************
  localparam logic [9:0] XROWS[10] = '{10'h003, 10'h00F, 10'h107, 10'h20B, 10'h140,
    10'h240, 10'h040, 10'h2FF, 10'h14A, 10'h3B1};
  localparam logic [16:0] RROWS[5] = '{17'h10303, 17'h10001, 17'h0050D, 17'h11010,
    17'h00E0E};

  arec_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .sfr_req_i(req),
    .sfr_rdata_o(rdata), .chop_disable_bit_i(chop_i), .cal_active_i(cal_i),
    .mod_tick_i(tick), .prim_pair_i(pair), .conv_done_o(done),
    .decimation_value_o(dval), .exc_o(exc));
  arec_mod_model fe (.clk_i(clk_i), .rstn_i(rstn_i), .gap_i(gap), .tick_o(tick));

  function automatic arec_pkg::arec_exc_t exp_exc(input logic [7:0] w, input logic [1:0] p);
    arec_pkg::arec_exc_t e;
    e.src1_analog_input_seven = w[0] & ~w[2];
    e.src1_analog_input_eight = w[0] & w[2];
    e.src2_analog_input_seven = w[1] & w[3];
    e.src2_analog_input_eight = w[1] & ~w[3];
    e.analog_input_seven_count = {1'b0, e.src1_analog_input_seven} + {1'b0, e.src2_analog_input_seven};
    e.analog_input_eight_count = {1'b0, e.src1_analog_input_eight} + {1'b0, e.src2_analog_input_eight};
    e.burnout_56 = w[6] & (p == 2'h1);
    e.burnout_78 = w[6] & (p == 2'h2);
    return e;
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_i);
    req.rd <= 1'b0;
    @(negedge clk_i);
    v = rdata;
  endtask

  // Ticks counted strictly between two done strobes
  task automatic meas(input int exp);
    int n;
    int k;
    n = 0;
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(negedge clk_i);
      k++;
    end
    @(negedge clk_i);
    while (done !== 1'b1 && k < 20000) begin
      if (tick === 1'b1) n++;
      @(negedge clk_i);
      k++;
    end
    cmp(16'(n), 16'(exp));
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    wrap_up();
  end

  initial begin
    rstn_i = 1'b0;
    ce_i = 1'b1;
    chop_i = 1'b0;
    cal_i = 1'b0;
    pair = 2'h0;
    gap = 4'h3;
    req = '0;
    err_count = 0;
    check_count = 0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    cmp(16'(dval), 16'(arec_pkg::DECIM_RESET));
    cmp(16'(exc), 16'h0000);
    rd(arec_pkg::DECIM_ADDR, d);
    cmp(16'(d), 16'h0045);
    rd(arec_pkg::EXC_ADDR, d);
    cmp(16'(d), 16'h0000);
    // Unmapped place: write dropped, read gives zero
    wr(8'hD6, 8'hFF);
    rd(8'hD6, d);
    cmp(16'(d), 16'h0000);
    rd(arec_pkg::EXC_ADDR, d);
    cmp(16'(d), 16'h0000);
    // ****************************************
    // Excitation table
    // ****************************************
    foreach (XROWS[i]) begin
      @(posedge clk_i);
      pair <= XROWS[i][9:8];
      wr(arec_pkg::EXC_ADDR, XROWS[i][7:0]);
      repeat (2) @(negedge clk_i);
      cmp(16'(exc), 16'(exp_exc(XROWS[i][7:0], XROWS[i][9:8])));
      rd(arec_pkg::EXC_ADDR, d);
      cmp(16'(d), 16'(XROWS[i][7:0] & 8'h4F));
    end
    // ****************************************
    // Rate table
    // ****************************************
    foreach (RROWS[i]) begin
      @(posedge clk_i);
      chop_i <= RROWS[i][16];
      wr(arec_pkg::DECIM_ADDR, RROWS[i][15:8]);
      repeat (2) @(negedge clk_i);
      cmp(16'(dval), 16'(RROWS[i][7:0]));
      rd(arec_pkg::DECIM_ADDR, d);
      cmp(16'(d), 16'(RROWS[i][15:8]));
      meas(int'(RROWS[i][7:0]) * (RROWS[i][16] ? 8 : 24));
    end
    // Calibration on the full word, slow timebase, excitation write mid-conversion
    @(posedge clk_i);
    chop_i <= 1'b1;
    gap <= 4'h7;
    wr(arec_pkg::DECIM_ADDR, 8'hFF);
    cal_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    cmp(16'(dval), 16'h00FF);
    wr(arec_pkg::DECIM_ADDR, 8'h03);
    meas(24);
    fork
      meas(24);
      begin
        repeat (60) @(posedge clk_i);
        wr(arec_pkg::EXC_ADDR, 8'h03);
      end
    join
    // Results before the fourth one after the source change are not trusted
    repeat (2) meas(24);
    cmp(16'(dval), 16'h0003);
    cmp(16'(exc), 16'(exp_exc(8'h03, 2'h3)));
    // Clock enable low: a write is not taken
    @(posedge clk_i);
    cal_i <= 1'b0;
    ce_i <= 1'b0;
    wr(arec_pkg::DECIM_ADDR, 8'h20);
    ce_i <= 1'b1;
    rd(arec_pkg::DECIM_ADDR, d);
    cmp(16'(d), 16'h0003);
    // Second reset in mid-run
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    cmp(16'(dval), 16'h0045);
    cmp(16'(exc), 16'h0000);
    rd(arec_pkg::DECIM_ADDR, d);
    cmp(16'(d), 16'h0045);
    rd(arec_pkg::EXC_ADDR, d);
    cmp(16'(d), 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
